// ==== verilog/timer_cc_pkg.sv ====
// Purpose: constants, register indices and field layouts of the capture/compare timer
// Assumes: APB slave with 32-bit data; each register is one word at byte address 4 * index
// Notes: register data sits in bits 7:0, upper bits read as zero
// Contract
// - Counter clock is one of seven prescaled bus rates or the external clock pin.
// - Active edge on a capture channel pin copies the counter into its value pair.
// - Software picks rising, falling or either edge per channel for capture.
// - Capture on a channel with interrupt enable raises an interrupt request.
// - Counter equal to compare value sets, clears or toggles the channel pin.
// - Compare match on a channel with interrupt enable raises an interrupt request.
// - Unbuffered value write takes effect at once, no shadow copy.
// - Writing a value already passed gives no match that overflow period.
// - Compare interrupt flag asserts at the moment of the compare match.
// - Overflow interrupt flag asserts at the end of each counter period.
// - Pair link bit in channel 0 joins channels 0/1, channel 0 pin, values 0 first.
// - Linked 0/1: last written pair takes control at each following overflow.
// - Linked 0/1: channel 0 control governs, channel 1 control and pin unused.
// - Pair link bit in channel 2 joins channels 2/3, channel 2 pin, values 2 first.
// - Linked 2/3: last written pair takes control at each following overflow.
// - Linked 2/3: channel 2 control governs, channel 3 control and pin unused.
// - One 16-bit free or modulo counter; reads never disturb counting.
// - Toggle-on-overflow bit toggles the channel pin at each counter overflow; the code toggles only in compare mode with a pin action.
package timer_cc_pkg;

  localparam int NUM_CHAN = 4;

  // Register indices; byte address is four times the index
  localparam logic [6:0]      IDX_STATUS  = 7'h3f;
  localparam logic [6:0]      IDX_CNT_HI  = 7'h40;
  localparam logic [6:0]      IDX_CNT_LO  = 7'h41;
  localparam logic [6:0]      IDX_MOD_HI  = 7'h42;
  localparam logic [6:0]      IDX_MOD_LO  = 7'h43;
  localparam logic [3:0][6:0] IDX_CH_CTRL = {7'h4d, 7'h4a, 7'h47, 7'h44};
  localparam logic [3:0][6:0] IDX_CH_HI   = {7'h4e, 7'h4b, 7'h48, 7'h45};
  localparam logic [3:0][6:0] IDX_CH_LO   = {7'h4f, 7'h4c, 7'h49, 7'h46};

  // Values after reset
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] MOD_RESET    = 16'hffff;
  localparam logic [15:0] CNT_RESET    = 16'h0000;

  // Clock source select code for the external pin; 0..6 divide by 2**code
  localparam logic [2:0] SRC_EXTERNAL = 3'h7;
  localparam int         PRESCALE_W   = 6;

  // Status and control register layout
  typedef struct packed {
    logic       wrapFlag;
    logic       wrapIrqEnable;
    logic       counterStop;
    logic       counterReset;
    logic       unused;
    logic [2:0] clockSourceSelect;
  } timer_status_t;

  // Channel status and control register layout
  typedef struct packed {
    logic eventFlag;
    logic irqEnable;
    logic modeHigh;
    logic modeLow;
    logic edgeLevelHigh;
    logic edgeLevelLow;
    logic toggleOnWrap;
    logic fullDuty;
  } chan_ctrl_t;

endpackage : timer_cc_pkg

// ==== verilog/timer_capture_compare_channels.sv ====
// Purpose: four-channel capture/compare timer with prescaler and buffered compare pairs
// Assumes: APB slave, no wait state per transfer; pins are asynchronous to clk
// Notes: value registers carry no reset; counter reads are taken live
//
// Implementation choice: the APB slave port.
module timer_capture_compare_channels
  import timer_cc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                clk,          // 50 MHz bus clock
  input  wire logic                rst_b,        // Asynchronous reset, active low
  input  wire logic                psel,         // APB select
  input  wire logic                penable,      // APB enable
  input  wire logic                pwrite,       // APB direction, high for write
  input  wire logic [ADDR_W-1:0]   paddr,        // APB byte address
  input  wire logic [31:0]         pwdata,       // APB write data
  output logic      [31:0]         prdata,       // APB read data
  output logic                     pready,       // APB ready
  output logic                     pslverr,      // APB error on unmapped address
  input  wire logic                extClockPin,  // External timer clock pin
  input  wire logic [NUM_CHAN-1:0] chanPinIn,    // Channel pin levels
  output logic      [NUM_CHAN-1:0] chanPinOut,   // Channel pin drive values
  output logic      [NUM_CHAN-1:0] chanPinOe,    // Channel pin output enables
  output logic      [NUM_CHAN-1:0] chanIrq,      // Channel interrupt requests
  output logic                     wrapIrq       // Overflow interrupt request
);

  // Timer state
  timer_status_t          statusReg;
  logic                   wrapArmed;
  logic [15:0]            countReg;
  logic [15:0]            moduloReg;
  logic [PRESCALE_W-1:0]  preCountReg;

  // Sync stages
  logic [2:0]             extSync;
  logic [NUM_CHAN-1:0]    pinSync1;
  logic [NUM_CHAN-1:0]    pinSync2;
  logic [NUM_CHAN-1:0]    pinSync3;

  // Channel state
  chan_ctrl_t             ctrlReg   [NUM_CHAN];
  logic                   flagArmed [NUM_CHAN];
  logic [15:0]            valueReg  [NUM_CHAN];
  logic [NUM_CHAN-1:0]    pinOutReg;
  logic [NUM_CHAN-1:0]    pinOeReg;
  logic [NUM_CHAN-1:0]    irqReg;
  logic                   wrapIrqReg;

  // Bus answer
  logic [31:0]            rdataReg;
  logic                   readyReg;
  logic                   errReg;

  // Decode
  logic [6:0]             regIdx;
  logic                   wrEn;
  logic                   rdEn;
  logic                   hit;
  logic [7:0]             rdByte;
  logic [7:0]             wrByte;
  logic [PRESCALE_W-1:0]  divMask;
  logic                   preTick;
  logic                   countTick;
  logic                   wrap;
  logic                   trstWrite;

  // Output flops
  assign prdata     = rdataReg;
  assign pready     = readyReg;
  assign pslverr    = errReg;
  assign chanPinOut = pinOutReg;
  assign chanPinOe  = pinOeReg;
  assign chanIrq    = irqReg;
  assign wrapIrq    = wrapIrqReg;

  // Bus decode
  // Access cycle only
  assign regIdx    = paddr[8:2];
  assign wrEn      = psel & penable & readyReg & pwrite;
  assign rdEn      = psel & penable & readyReg & ~pwrite;
  assign wrByte    = pwdata[7:0];
  assign trstWrite = wrEn && regIdx == IDX_STATUS && wrByte[4];

  // Two-stage synchronisers for pins
  // Stage 3 is edge-only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extSync  <= 3'h0;
      pinSync1 <= '0;
      pinSync2 <= '0;
      pinSync3 <= '0;
    end else begin
      extSync  <= {extSync[1:0], extClockPin};
      pinSync1 <= chanPinIn;
      pinSync2 <= pinSync1;
      pinSync3 <= pinSync2;
    end
  end

  // Prescaler and counter clock select
  // Divide by 2**select or pin edge
  assign divMask   = PRESCALE_W'((7'h01 << statusReg.clockSourceSelect) - 7'h01);
  assign preTick   = (preCountReg & divMask) == divMask;
  assign countTick = ~statusReg.counterStop &
                     ((statusReg.clockSourceSelect == SRC_EXTERNAL) ?
                      (extSync[1] & ~extSync[2]) : preTick);
  assign wrap      = countTick && countReg == moduloReg;

  // Prescaler divider
  // Reset write restarts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCountReg <= '0;
    end else if (trstWrite) begin
      preCountReg <= '0;
    end else begin
      preCountReg <= preCountReg + PRESCALE_W'(1);
    end
  end

  // Free-running or modulo up-counter
  // Reset write wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      countReg <= CNT_RESET;
    end else if (trstWrite) begin
      countReg <= CNT_RESET;
    end else if (wrap) begin
      countReg <= CNT_RESET;
    end else if (countTick) begin
      countReg <= countReg + 16'h0001;
    end
  end

  // Modulo register
  // Bytes apply at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      moduloReg <= MOD_RESET;
    end else if (wrEn && regIdx == IDX_MOD_HI) begin
      moduloReg[15:8] <= wrByte;
    end else if (wrEn && regIdx == IDX_MOD_LO) begin
      moduloReg[7:0] <= wrByte;
    end
  end

  // Timer status and control, overflow flag with read-then-clear
  // Reset bit not stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      statusReg <= STATUS_RESET;
      wrapArmed <= 1'b0;
    end else begin
      if (wrEn && regIdx == IDX_STATUS) begin
        statusReg.wrapIrqEnable     <= wrByte[6];
        statusReg.counterStop       <= wrByte[5];
        statusReg.clockSourceSelect <= wrByte[2:0];
      end
      if (wrap) begin
        statusReg.wrapFlag <= 1'b1;
      end else if (wrEn && regIdx == IDX_STATUS && !wrByte[7] && wrapArmed) begin
        statusReg.wrapFlag <= 1'b0;
      end
      // Any write disarms
      if (wrEn && regIdx == IDX_STATUS) begin
        wrapArmed <= 1'b0;
      end else if (rdEn && regIdx == IDX_STATUS && statusReg.wrapFlag) begin
        wrapArmed <= 1'b1;
      end
    end
  end

  // Overflow interrupt request
  // Flag and enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrapIrqReg <= 1'b0;
    end else begin
      wrapIrqReg <= statusReg.wrapFlag & statusReg.wrapIrqEnable;
    end
  end

  // Per-channel capture, compare, pin and pairing logic
  // Odd inert when linked
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    // Local decode
    logic        slave;
    logic        captureMode;
    logic        compareMode;
    logic [15:0] compareValue;
    logic        match;
    logic        capture;
    logic        driveOn;
    logic        pinWrapped;
    logic        writeHi;
    logic        writeLo;

    if (i % 2 == 1) begin : g_odd
      assign slave        = ctrlReg[i-1].modeHigh;
      assign compareValue = valueReg[i];
    end else begin : g_even
      logic activeOdd;
      logic lastOdd;
      logic partnerWrite;
      assign slave        = 1'b0;
      assign partnerWrite = wrEn && (regIdx == IDX_CH_HI[i+1] || regIdx == IDX_CH_LO[i+1]);

      // Buffered select: even pair first, last written pair at each overflow
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          activeOdd <= 1'b0;
          lastOdd   <= 1'b0;
        end else if (!ctrlReg[i].modeHigh) begin
          activeOdd <= 1'b0;
          lastOdd   <= 1'b0;
        end else begin
          if (partnerWrite) begin
            lastOdd <= 1'b1;
          end else if (writeHi || writeLo) begin
            lastOdd <= 1'b0;
          end
          if (wrap) begin
            // Same-edge write wins
            activeOdd <= partnerWrite ? 1'b1 : (writeHi || writeLo) ? 1'b0 : lastOdd;
          end
        end
      end
      // Active pair compared
      assign compareValue = (ctrlReg[i].modeHigh && activeOdd) ? valueReg[i+1] : valueReg[i];
    end

    // Writes and mode
    assign writeHi     = wrEn && regIdx == IDX_CH_HI[i];
    assign writeLo     = wrEn && regIdx == IDX_CH_LO[i];
    assign driveOn     = ctrlReg[i].edgeLevelHigh | ctrlReg[i].edgeLevelLow;
    assign captureMode = ~slave & ~ctrlReg[i].modeHigh & ~ctrlReg[i].modeLow & driveOn;
    assign compareMode = ~slave & (ctrlReg[i].modeHigh | ctrlReg[i].modeLow);
    // Equality only: a value already passed waits for the next period
    // Edges from stages 2 and 3
    assign match       = compareMode && countTick && countReg == compareValue;
    assign capture     = captureMode &
                         ((ctrlReg[i].edgeLevelLow  & pinSync2[i] & ~pinSync3[i]) |
                          (ctrlReg[i].edgeLevelHigh & ~pinSync2[i] & pinSync3[i]));
    // Toggle first
    assign pinWrapped  = (wrap && ctrlReg[i].toggleOnWrap) ? ~pinOutReg[i] : pinOutReg[i];

    // Control register and event flag
    // Write disarms flag
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        ctrlReg[i]   <= CTRL_RESET;
        flagArmed[i] <= 1'b0;
      end else begin
        if (wrEn && regIdx == IDX_CH_CTRL[i]) begin
          ctrlReg[i].irqEnable     <= wrByte[6];
          ctrlReg[i].modeHigh      <= (i % 2 == 0) ? wrByte[5] : 1'b0;
          ctrlReg[i].modeLow       <= wrByte[4];
          ctrlReg[i].edgeLevelHigh <= wrByte[3];
          ctrlReg[i].edgeLevelLow  <= wrByte[2];
          ctrlReg[i].toggleOnWrap  <= wrByte[1];
          ctrlReg[i].fullDuty      <= wrByte[0];
        end
        if (match || capture) begin
          ctrlReg[i].eventFlag <= 1'b1;
        end else if (wrEn && regIdx == IDX_CH_CTRL[i] && !wrByte[7] && flagArmed[i]) begin
          ctrlReg[i].eventFlag <= 1'b0;
        end
        if (wrEn && regIdx == IDX_CH_CTRL[i]) begin
          flagArmed[i] <= 1'b0;
        end else if (rdEn && regIdx == IDX_CH_CTRL[i] && ctrlReg[i].eventFlag) begin
          flagArmed[i] <= 1'b1;
        end
      end
    end

    // Value pair: capture wins, writes apply at once
    // Undefined until written
    always_ff @(posedge clk) begin
      if (capture) begin
        valueReg[i] <= countReg;
      end else if (writeHi) begin
        valueReg[i][15:8] <= wrByte;
      end else if (writeLo) begin
        valueReg[i][7:0] <= wrByte;
      end
    end

    // Pin drive: overflow toggle, then compare action
    // Compare with action
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pinOutReg[i] <= 1'b0;
        pinOeReg[i]  <= 1'b0;
      end else begin
        pinOeReg[i] <= compareMode & driveOn;
        if (match && driveOn) begin
          unique case ({ctrlReg[i].edgeLevelHigh, ctrlReg[i].edgeLevelLow})
            2'b01:   pinOutReg[i] <= ~pinWrapped;
            2'b10:   pinOutReg[i] <= 1'b0;
            default: pinOutReg[i] <= 1'b1;
          endcase
        end else if (compareMode && driveOn) begin
          pinOutReg[i] <= pinWrapped;
        end
      end
    end

    // Channel interrupt request
    // Flag and enable
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        irqReg[i] <= 1'b0;
      end else begin
        irqReg[i] <= ctrlReg[i].eventFlag & ctrlReg[i].irqEnable;
      end
    end
  end

  // Read data mux and address hit
  // Channels after the case
  always_comb begin
    rdByte = 8'h00;
    hit    = 1'b1;
    unique case (regIdx)
      IDX_STATUS: rdByte = {statusReg[7:5], 5'h00} | {5'h00, statusReg.clockSourceSelect};
      IDX_CNT_HI: rdByte = countReg[15:8];
      IDX_CNT_LO: rdByte = countReg[7:0];
      IDX_MOD_HI: rdByte = moduloReg[15:8];
      IDX_MOD_LO: rdByte = moduloReg[7:0];
      default:    hit    = 1'b0;
    endcase

    // Channel registers
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (regIdx == IDX_CH_CTRL[c]) begin
        rdByte = ctrlReg[c];
        hit    = 1'b1;
      end
      if (regIdx == IDX_CH_HI[c]) begin
        rdByte = valueReg[c][15:8];
        hit    = 1'b1;
      end
      if (regIdx == IDX_CH_LO[c]) begin
        rdByte = valueReg[c][7:0];
        hit    = 1'b1;
      end
    end
    // Misaligned or high miss
    if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:9] != '0) begin
      hit = 1'b0;
    end
  end

  // APB slave: no wait state, data and error latched in setup
  // Zero outside answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdataReg <= 32'h0000_0000;
      readyReg <= 1'b0;
      errReg   <= 1'b0;
    end else if (psel && !penable) begin
      rdataReg <= (hit && !pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
      readyReg <= 1'b1;
      errReg   <= ~hit;
    end else begin
      rdataReg <= 32'h0000_0000;
      readyReg <= 1'b0;
      errReg   <= 1'b0;
    end
  end

endmodule : timer_capture_compare_channels

// ==== sim/timer_cc_asserts.sv ====
// Purpose: port checks of the capture/compare timer
// Assumes: APB answers in the first access cycle, no wait state
// Notes: enable and link bits tracked from writes
module timer_cc_asserts
  import timer_cc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic                clk,         // Clock
  input wire logic                rst_b,       // Reset
  input wire logic                psel,        // Select
  input wire logic                penable,     // Enable
  input wire logic                pwrite,      // Direction
  input wire logic [ADDR_W-1:0]   paddr,       // Address
  input wire logic [31:0]         pwdata,      // Write data
  input wire logic [31:0]         prdata,      // Read data
  input wire logic                pready,      // Ready
  input wire logic                pslverr,     // Error
  input wire logic                extClockPin, // Ext clock
  input wire logic [NUM_CHAN-1:0] chanPinIn,   // Pin levels
  input wire logic [NUM_CHAN-1:0] chanPinOut,  // Pin drive
  input wire logic [NUM_CHAN-1:0] chanPinOe,   // Pin enables
  input wire logic [NUM_CHAN-1:0] chanIrq,     // Channel irqs
  input wire logic                wrapIrq      // Overflow irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wrHit;
  logic       badAddr;
  logic [6:0] idx;
  logic       wrapEn_reg;
  logic [3:0] chEn_reg;
  logic [1:0] link_reg;
  // Decoded write and address class
  assign idx     = paddr[8:2];
  assign wrHit   = psel && penable && pready && pwrite && !pslverr;
  assign badAddr = paddr[1:0] != 2'h0 || (paddr >> 9) != '0 || idx < IDX_STATUS || idx > 7'h4f;
  // Enable and link bits as written
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrapEn_reg <= 1'b0;
      chEn_reg   <= 4'h0;
      link_reg   <= 2'h0;
    end else if (wrHit) begin
      if (idx == IDX_STATUS) wrapEn_reg <= pwdata[6];
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (idx == IDX_CH_CTRL[i]) chEn_reg[i] <= pwdata[6];
      end
      if (idx == IDX_CH_CTRL[0]) link_reg[0] <= pwdata[5];
      if (idx == IDX_CH_CTRL[2]) link_reg[1] <= pwdata[5];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_ready_wait: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_rdata_upper: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_err_unmapped: assert property (pready && badAddr |-> pslverr)
    else $error("unmapped access accepted");
  a_err_mapped: assert property (pready && !badAddr |-> !pslverr)
    else $error("mapped access refused");
  a_pair01_free: assert property (link_reg[0] && $past(link_reg[0]) |-> !chanPinOe[1])
    else $error("linked odd pin 1 driven");
  a_pair23_free: assert property (link_reg[1] && $past(link_reg[1]) |-> !chanPinOe[3])
    else $error("linked odd pin 3 driven");
  a_wrap_irq_en: assert property (!wrapEn_reg && !$past(wrapEn_reg) |-> !wrapIrq)
    else $error("overflow irq while disabled");
  a_chan_irq_en: assert property ((chanIrq & ~chEn_reg & ~$past(chEn_reg)) == 4'h0)
    else $error("channel irq while disabled");
  c_write: cover property (wrHit);
  c_refused: cover property (pready && pslverr);
  c_chan_irq: cover property ($rose(chanIrq[2]));
  c_wrap_irq: cover property ($rose(wrapIrq));
endmodule : timer_cc_asserts
bind timer_capture_compare_channels timer_cc_asserts #(.ADDR_W(ADDR_W)) chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .extClockPin(extClockPin), .chanPinIn(chanPinIn), .chanPinOut(chanPinOut),
  .chanPinOe(chanPinOe), .chanIrq(chanIrq), .wrapIrq(wrapIrq));

// ==== sim/pin_partner.sv ====
// Purpose: event sources and loads on the channel pins
// Assumes: device drive wins over the source
// Notes: external clock stands low between pulses
module pin_partner
  import timer_cc_pkg::*;
(
  input  wire logic                clk,         // Clock
  input  wire logic [NUM_CHAN-1:0] chanPinOut,  // Device drive
  input  wire logic [NUM_CHAN-1:0] chanPinOe,   // Device enables
  output logic      [NUM_CHAN-1:0] chanPinIn,   // Wire levels
  output logic                     extClockPin  // Ext clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_CHAN-1:0] srcLevel;
  // Wire level per pin
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) chanPinIn[i] = chanPinOe[i] ? chanPinOut[i] : srcLevel[i];
  end
  // Quiet lines at start
  initial begin
    srcLevel    = '0;
    extClockPin = 1'b0;
  end
  task setSrc(input int ch, input logic lvl);
    @(posedge clk);
    srcLevel[ch] <= lvl;
  endtask : setSrc
  task extPulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      extClockPin <= 1'b1;
      repeat (3) @(posedge clk);
      extClockPin <= 1'b0;
    end
  endtask : extPulses
endmodule : pin_partner

// ==== sim/timer_capture_compare_channels_tb_top.sv ====
// Purpose: self-checking bench of the capture/compare timer
// Assumes: APB master, one transfer at a time
// Notes: random values from a fixed seed
module timer_capture_compare_channels_tb_top
  import timer_cc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, extClockPin, wrapIrq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  chanPinIn, chanPinOut, chanPinOe, chanIrq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          seed = 99690;
  timer_capture_compare_channels #(.ADDR_W(12)) uut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extClockPin(extClockPin), .chanPinIn(chanPinIn), .chanPinOut(chanPinOut),
    .chanPinOe(chanPinOe), .chanIrq(chanIrq), .wrapIrq(wrapIrq));
  pin_partner partner (.clk(clk), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe),
    .chanPinIn(chanPinIn), .extClockPin(extClockPin));
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic pinAfter(input logic [1:0] code, input logic prev);
    return (code == 2'h3) ? 1'b1 : (code == 2'h2) ? 1'b0 : ~prev;
  endfunction : pinAfter
  function automatic logic edgeHit(input logic [1:0] code, input logic rise);
    return rise ? code[0] : code[1];
  endfunction : edgeHit
  task summarize;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task checkVal(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : checkVal
  task checkIn(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("[ERR] %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : checkIn
  task apb(input logic [6:0] i, input logic w, input logic [7:0] d, output logic [7:0] r, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {3'h0, i, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [6:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(i, 1'b1, d, r, e);
  endtask : wr
  task rdChk(input logic [6:0] i, input logic [7:0] x);
    logic [7:0] r;
    logic       e;
    apb(i, 1'b0, 8'h00, r, e);
    checkVal({7'h0, e, r}, {8'h0, x});
  endtask : rdChk
  task measureLow(input int ch, output logic [15:0] len);
    int n;
    n = 0;
    while (chanPinOut[ch] !== 1'b1 && n < 300) begin @(posedge clk); n++; end
    while (chanPinOut[ch] !== 1'b0 && n < 300) begin @(posedge clk); n++; end
    len = 0;
    while (chanPinOut[ch] !== 1'b1 && len < 300) begin @(posedge clk); len++; end
  endtask : measureLow
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [7:0]  r, v;
    logic        e, expPin;
    logic [1:0]  code;
    logic [15:0] len;
    logic [31:0] rnd;
    int          d;
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) rdChk(IDX_CH_CTRL[i], CTRL_RESET);
    rdChk(IDX_STATUS, STATUS_RESET);
    rdChk(IDX_MOD_LO, MOD_RESET[7:0]);
    wr(7'h10, 8'h5a);
    apb(7'h10, 1'b0, 8'h00, r, e);
    checkVal({7'h0, e, r}, 16'h100);
    // Prescaler rates, then external clock
    for (int s = 0; s < 7; s++) begin
      wr(IDX_STATUS, 8'h10 | 8'(s));
      repeat (128) @(posedge clk);
      wr(IDX_STATUS, 8'h20 | 8'(s));
      apb(IDX_CNT_LO, 1'b0, 8'h00, r, e);
      checkIn({8'h0, r}, 16'(130 >> s) - 16'd1, 16'(130 >> s) + 16'd2);
    end
    rnd = $random(seed);
    d = 3 + int'(rnd[1:0]);
    wr(IDX_STATUS, 8'h17);
    partner.extPulses(d);
    repeat (4) @(posedge clk);
    apb(IDX_CNT_LO, 1'b0, 8'h00, r, e);
    checkVal({8'h0, r}, 16'(d));
    // Compare actions set, clear, toggle
    expPin = 1'b0;
    for (int k = 0; k < 3; k++) begin
      rnd = $random(seed);
      v = 8'h10 + {2'h0, rnd[5:0]};
      code = 2'h3 - 2'(k);
      wr(IDX_STATUS, 8'h30);
      wr(IDX_CH_HI[2], 8'h00);
      wr(IDX_CH_LO[2], v);
      wr(IDX_CH_CTRL[2], {4'h5, code, 2'h0});
      wr(IDX_STATUS, 8'h00);
      repeat (100) @(posedge clk);
      wr(IDX_STATUS, 8'h20);
      expPin = pinAfter(code, expPin);
      checkVal({15'h0, chanPinOut[2]}, {15'h0, expPin});
      checkVal({14'h0, chanIrq[2], chanPinOe[2]}, 16'h3);
      rdChk(IDX_CH_CTRL[2], {4'hd, code, 2'h0});
      wr(IDX_CH_CTRL[2], {4'h5, code, 2'h0});
      rdChk(IDX_CH_CTRL[2], {4'h5, code, 2'h0});
    end
    // Passed value misses, new value applies at once
    wr(IDX_STATUS, 8'h30);
    wr(IDX_CH_LO[2], 8'hf0);
    wr(IDX_STATUS, 8'h00);
    repeat (64) @(posedge clk);
    wr(IDX_CH_LO[2], 8'h20);
    repeat (96) @(posedge clk);
    wr(IDX_STATUS, 8'h20);
    rdChk(IDX_CH_CTRL[2], 8'h54);
    wr(IDX_CH_LO[2], 8'hc0);
    wr(IDX_STATUS, 8'h00);
    repeat (48) @(posedge clk);
    rdChk(IDX_CH_CTRL[2], 8'hd4);
    // Input capture edges on channel 1
    for (int k = 1; k < 4; k++) begin
      wr(IDX_CH_CTRL[1], {4'h0, 2'(k), 2'h0});
      wr(IDX_STATUS, 8'h10);
      rnd = $random(seed);
      d = 32 + int'(rnd[5:0]);
      repeat (d) @(posedge clk);
      partner.setSrc(1, 1'b1);
      repeat (8) @(posedge clk);
      checkVal({15'h0, chanPinOe[1]}, 16'h0);
      rdChk(IDX_CH_CTRL[1], {edgeHit(2'(k), 1'b1), 3'h0, 2'(k), 2'h0});
      apb(IDX_CH_LO[1], 1'b0, 8'h00, r, e);
      if (k == 1) checkIn({8'h0, r}, 16'(d), 16'(d + 6));
      wr(IDX_CH_CTRL[1], {4'h0, 2'(k), 2'h0});
      partner.setSrc(1, 1'b0);
      repeat (8) @(posedge clk);
      rdChk(IDX_CH_CTRL[1], {edgeHit(2'(k), 1'b0), 3'h0, 2'(k), 2'h0});
    end
    // Buffered pairs with overflow toggle
    wr(IDX_MOD_HI, 8'h00);
    wr(IDX_MOD_LO, 8'h3f);
    for (int p = 0; p < 4; p += 2) begin
      wr(IDX_STATUS, 8'h30);
      wr(IDX_CH_HI[p], 8'h00);
      wr(IDX_CH_LO[p], 8'h10);
      wr(IDX_CH_CTRL[p], 8'h2e);
      wr(IDX_STATUS, 8'h40);
      measureLow(p, len);
      checkIn(len, 16'h10, 16'h12);
      checkVal({15'h0, chanPinOe[p + 1]}, 16'h0);
      wr(IDX_CH_HI[p + 1], 8'h00);
      wr(IDX_CH_LO[p + 1], 8'h30);
      measureLow(p, len);
      checkIn(len, 16'h30, 16'h32);
      wr(IDX_CH_LO[p], 8'h20);
      measureLow(p, len);
      checkIn(len, 16'h20, 16'h22);
      checkVal({15'h0, wrapIrq}, 16'h1);
      rdChk(IDX_STATUS, 8'hc0);
      wr(IDX_CH_CTRL[p], 8'h00);
    end
    summarize();
  end
endmodule : timer_capture_compare_channels_tb_top
